// >>> rtl/sttx_exec.v
`timescale 1ns/1ps
`include "sttx_defines.vh"
// What this block does
// - Subtract adds source two's complement to destination
// - Carry cleared on carry out, else borrow
// - Zero and sign follow the subtract result
// - Overflow: opposite signs, result sign equals source
// - Byte subtract sets D; others keep it
// - Byte subtract H marks nibble borrow; others keep
// - True condition sets destination bit 0 only
// - Probe ORs with zero, never writes operand
// - Probe sets Z, copies MSB to S
// - Probe V: byte parity, word kept, long undefined
// - Translate: table base plus zero-extended byte
// - Descending: pointer and counter minus one
// - Ascending: pointer plus one, counter minus one
// - Single step: V when counter reaches zero
// - Translate leaves scratch high byte undefined
// - Repeat until counter zero, 1..65536 bytes
// - Repeat interruptible between bytes, seven cycles extra
// - Single 25 cycles; repeat 11 plus 14n
module sttx_exec (
  input  wire        ref_clk,               // 40 MHz clock
  input  wire        rst,                   // Async reset, active high
  input  wire        start,                 // Begin operation, ignored while busy
  input  wire [2:0]  op,                    // Operation code
  input  wire [1:0]  size,                  // Operand size
  input  wire [3:0]  cond,                  // Condition selector
  input  wire [31:0] dst_val,               // Destination register value
  input  wire [31:0] src_val,               // Source register value
  input  wire [5:0]  flags_in,              // Flags at start
  input  wire [15:0] ptr_in,                // String pointer
  input  wire [15:0] base_in,               // Table base address
  input  wire [15:0] cnt_in,                // Word counter
  input  wire [15:0] pc_in,                 // Address of instruction start
  input  wire        irq_req,               // Interrupt request pin
  input  wire        rd_ack,                // Memory read done
  input  wire [7:0]  rd_data,               // Memory read byte
  input  wire        wr_ready,              // Memory accepts write
  output reg         rd_valid,              // Memory read request
  output reg  [15:0] rd_addr,               // Memory read address
  output reg         wr_valid,              // Memory write request
  output reg  [15:0] wr_addr,               // Memory write address
  output reg  [7:0]  wr_data,               // Memory write byte
  output reg         busy,                  // Operation in progress
  output reg         done,                  // Operation finished
  output reg  [31:0] result,                // Destination result
  output reg         result_we,             // Write result back
  output reg  [5:0]  flags_out,             // Resulting flags
  output reg  [15:0] ptr_out,               // Updated pointer
  output reg  [15:0] cnt_out,               // Updated counter
  output reg  [7:0]  scratch_high_byte_reg, // Clobbered scratch byte
  output reg         scratch_we,            // Scratch byte written
  output reg         irq_ack,               // Interrupt taken
  output reg  [15:0] resume_pc              // Resume address
);

  reg  [2:0]  state_ff;
  reg  [4:0]  timer_ff;
  reg  [2:0]  op_ff;
  reg  [15:0] base_ff;
  reg  [7:0]  xl_ff;
  reg         irq_s1_ff;
  reg         irq_s2_ff;
  reg         irq_s3_ff;
  reg         irq_lvl_ff;
  reg         alu_we_hold;
  wire [31:0] alu_result;
  wire        alu_we;
  wire [5:0]  alu_flags;
  wire        fifo_in_valid;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [23:0] fifo_out_data;
  wire        is_xlate;

  // Cycles to load into the pace timer at acceptance, minus one
  function [4:0] first_cyc;
    input [2:0] o;
    input [1:0] s;
    begin
      case (o)
        `STTX_OP_MINUS:
          first_cyc = (s == `STTX_SZ_LONG) ? `STTX_CYC_MINUS_L : `STTX_CYC_MINUS_WB;
        `STTX_OP_PROBE:
          first_cyc = (s == `STTX_SZ_LONG) ? `STTX_CYC_PROBE_L : `STTX_CYC_PROBE_WB;
        `STTX_OP_CBSET:
          first_cyc = `STTX_CYC_CBSET;
        `STTX_OP_XDREP:
          first_cyc = `STTX_CYC_XREP_INIT + `STTX_CYC_XREP_BYTE;
        default:
          first_cyc = `STTX_CYC_XSINGLE;
      endcase
      first_cyc = first_cyc - 5'h01;
    end
  endfunction

  assign is_xlate = (op == `STTX_OP_XDOWN) || (op == `STTX_OP_XDREP) || (op == `STTX_OP_XUP);

  sttx_alu u_alu (
    .op        (op),
    .size      (size),
    .cond      (cond),
    .dst       (dst_val),
    .src       (src_val),
    .flags_in  (flags_in),
    .result    (alu_result),
    .result_we (alu_we),
    .flags_out (alu_flags)
  );

  assign fifo_in_valid  = (state_ff == `STTX_ST_PUSH);
  assign fifo_out_ready = ~wr_valid | wr_ready;

  sttx_fifo #(
    .W  (`STTX_WB_W),
    .D  (`STTX_WB_D),
    .AW (`STTX_WB_AW)
  ) u_wb_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({ptr_out, xl_ff}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Interrupt pin synchroniser; level moves only when stages two and three agree
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_s1_ff  <= 1'b0;
      irq_s2_ff  <= 1'b0;
      irq_s3_ff  <= 1'b0;
      irq_lvl_ff <= 1'b0;
    end
    else
    begin
      irq_s1_ff <= irq_req;
      irq_s2_ff <= irq_s1_ff;
      irq_s3_ff <= irq_s2_ff;
      if (irq_s2_ff == irq_s3_ff)
        irq_lvl_ff <= irq_s3_ff;
    end
  end

  // Memory write stage after the buffer
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_valid <= 1'b0;
      wr_addr  <= 16'h0000;
      wr_data  <= 8'h00;
    end
    else if (fifo_out_valid & fifo_out_ready)
    begin
      wr_valid <= 1'b1;
      wr_addr  <= fifo_out_data[23:8];
      wr_data  <= fifo_out_data[7:0];
    end
    else if (wr_ready)
      wr_valid <= 1'b0;
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff              <= `STTX_ST_IDLE;
      timer_ff              <= 5'h00;
      op_ff                 <= `STTX_OP_MINUS;
      base_ff               <= 16'h0000;
      xl_ff                 <= 8'h00;
      rd_valid              <= 1'b0;
      rd_addr               <= 16'h0000;
      busy                  <= 1'b0;
      done                  <= 1'b0;
      result                <= 32'h00000000;
      result_we             <= 1'b0;
      flags_out             <= 6'h00;
      ptr_out               <= 16'h0000;
      cnt_out               <= 16'h0000;
      scratch_high_byte_reg <= 8'h00;
      scratch_we            <= 1'b0;
      irq_ack               <= 1'b0;
      resume_pc             <= 16'h0000;
    end
    else
    begin
      done       <= 1'b0;
      result_we  <= 1'b0;
      scratch_we <= 1'b0;
      irq_ack    <= 1'b0;
      if (timer_ff != 5'h00)
        timer_ff <= timer_ff - 5'h01;
      case (state_ff)
        `STTX_ST_IDLE:
        begin
          if (start)
          begin
            busy      <= 1'b1;
            op_ff     <= op;
            timer_ff  <= first_cyc(op, size);
            flags_out <= alu_flags;
            result    <= alu_result;
            resume_pc <= pc_in;
            ptr_out   <= ptr_in;
            cnt_out   <= cnt_in;
            base_ff   <= base_in;
            if (is_xlate)
            begin
              flags_out <= flags_in;
              state_ff  <= `STTX_ST_RTGT;
              rd_valid  <= 1'b1;
              rd_addr   <= ptr_in;
            end
            else
              state_ff <= `STTX_ST_ALU;
          end
        end
        `STTX_ST_ALU:
        begin
          if (timer_ff == 5'h00)
          begin
            done      <= 1'b1;
            busy      <= 1'b0;
            result_we <= alu_we_hold;
            state_ff  <= `STTX_ST_IDLE;
          end
        end
        `STTX_ST_RTGT:
        begin
          if (rd_ack)
          begin
            rd_addr  <= base_ff + {8'h00, rd_data};
            state_ff <= `STTX_ST_RTBL;
          end
        end
        `STTX_ST_RTBL:
        begin
          if (rd_ack)
          begin
            rd_valid              <= 1'b0;
            xl_ff                 <= rd_data;
            scratch_high_byte_reg <= rd_data;
            scratch_we            <= 1'b1;
            state_ff              <= `STTX_ST_PUSH;
          end
        end
        `STTX_ST_PUSH:
        begin
          if (fifo_in_ready)
          begin
            if (op_ff == `STTX_OP_XUP)
              ptr_out <= ptr_out + 16'h0001;
            else
              ptr_out <= ptr_out - 16'h0001;
            cnt_out <= cnt_out - 16'h0001;
            flags_out[`STTX_FL_V] <= (cnt_out == 16'h0001);
            state_ff <= `STTX_ST_PACE;
          end
        end
        `STTX_ST_PACE:
        begin
          if (timer_ff == 5'h00)
          begin
            if ((op_ff != `STTX_OP_XDREP) || (cnt_out == 16'h0000))
            begin
              done     <= 1'b1;
              busy     <= 1'b0;
              state_ff <= `STTX_ST_IDLE;
            end
            else if (irq_lvl_ff)
            begin
              irq_ack  <= 1'b1;
              timer_ff <= `STTX_CYC_IRQ - 5'h01;
              state_ff <= `STTX_ST_IRQ;
            end
            else
            begin
              timer_ff <= `STTX_CYC_XREP_BYTE - 5'h01;
              rd_valid <= 1'b1;
              rd_addr  <= ptr_out;
              state_ff <= `STTX_ST_RTGT;
            end
          end
        end
        `STTX_ST_IRQ:
        begin
          if (timer_ff == 5'h00)
          begin
            done     <= 1'b1;
            busy     <= 1'b0;
            state_ff <= `STTX_ST_IDLE;
          end
        end
        default:
        begin
          state_ff <= `STTX_ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      alu_we_hold <= 1'b0;
    else if (start && (state_ff == `STTX_ST_IDLE))
      alu_we_hold <= alu_we;
  end

endmodule

// >>> rtl/sttx_defines.vh
`ifndef STTX_DEFINES_VH
`define STTX_DEFINES_VH

// Operation codes (byte_minus_op and long_minus_op share the subtract code)
`define STTX_OP_MINUS      3'h0
`define STTX_OP_PROBE      3'h1
`define STTX_OP_CBSET      3'h2
`define STTX_OP_XDOWN      3'h3
`define STTX_OP_XDREP      3'h4
`define STTX_OP_XUP        3'h5

// Operand sizes
`define STTX_SZ_BYTE       2'h0
`define STTX_SZ_WORD       2'h1
`define STTX_SZ_LONG       2'h2

// Flag vector bit positions
`define STTX_FL_C          5
`define STTX_FL_Z          4
`define STTX_FL_S          3
`define STTX_FL_V          2
`define STTX_FL_D          1
`define STTX_FL_H          0

// Execution times in processor cycles (one ref_clk cycle each)
`define STTX_CYC_MINUS_WB  5'h04
`define STTX_CYC_MINUS_L   5'h08
`define STTX_CYC_PROBE_WB  5'h07
`define STTX_CYC_PROBE_L   5'h0D
`define STTX_CYC_CBSET     5'h05
`define STTX_CYC_XSINGLE   5'h19
`define STTX_CYC_XREP_INIT 5'h0B
`define STTX_CYC_XREP_BYTE 5'h0E
`define STTX_CYC_IRQ       5'h07

// Write-back buffer shape
`define STTX_WB_W          24
`define STTX_WB_D          8
`define STTX_WB_AW         3

// Execution states
`define STTX_ST_IDLE       3'h0
`define STTX_ST_ALU        3'h1
`define STTX_ST_RTGT       3'h2
`define STTX_ST_RTBL       3'h3
`define STTX_ST_PUSH       3'h4
`define STTX_ST_PACE       3'h5
`define STTX_ST_IRQ        3'h6

`endif

// >>> rtl/sttx_fifo.v
`timescale 1ns/1ps
module sttx_fifo #(
  parameter W  = 24,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         ref_clk,   // Clock
  input  wire         rst,       // Async reset, active high
  input  wire         in_valid,  // Write request
  output wire         in_ready,  // Space available
  input  wire [W-1:0] in_data,   // Write word
  output wire         out_valid, // Word available
  input  wire         out_ready, // Drain accepts
  output wire [W-1:0] out_data   // Head word
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_ff;
  reg [AW-1:0] rp_ff;
  reg [AW:0]   cnt_ff;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_ff != D[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge ref_clk)
  begin
    if (push)
      mem[wp_ff] <= in_data;
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_ff  <= {AW{1'b0}};
      rp_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_ff <= wp_ff + 1'b1;
      if (pop)
        rp_ff <= rp_ff + 1'b1;
      if (push & ~pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop & ~push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule

// >>> rtl/sttx_alu.v
`timescale 1ns/1ps
`include "sttx_defines.vh"
module sttx_alu (
  input  wire [2:0]  op,        // Operation code
  input  wire [1:0]  size,      // Operand size
  input  wire [3:0]  cond,      // Condition selector
  input  wire [31:0] dst,       // Destination operand
  input  wire [31:0] src,       // Source operand
  input  wire [5:0]  flags_in,  // Current flags
  output reg  [31:0] result,    // Destination result
  output reg         result_we, // Destination written
  output reg  [5:0]  flags_out  // Resulting flags
);

  wire [8:0]  sb  = {1'b0, dst[7:0]} + {1'b0, ~src[7:0]} + 9'h001;
  wire [16:0] sw  = {1'b0, dst[15:0]} + {1'b0, ~src[15:0]} + 17'h00001;
  wire [32:0] sl  = {1'b0, dst} + {1'b0, ~src} + 33'h000000001;
  wire [4:0]  nib = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;

  reg [31:0] dif;
  reg        cy;
  reg        rm;
  reg        dm;
  reg        sm;
  reg        zz;
  reg        pz;
  reg        ps;

  // Standard four-bit condition table shared with conditional jumps
  function cond_true;
    input [3:0] cc;
    input [5:0] f;
    reg c;
    reg z;
    reg s;
    reg v;
    begin
      c = f[`STTX_FL_C];
      z = f[`STTX_FL_Z];
      s = f[`STTX_FL_S];
      v = f[`STTX_FL_V];
      case (cc)
        4'h0: cond_true = 1'b0;
        4'h1: cond_true = s ^ v;
        4'h2: cond_true = z | (s ^ v);
        4'h3: cond_true = c | z;
        4'h4: cond_true = v;
        4'h5: cond_true = s;
        4'h6: cond_true = z;
        4'h7: cond_true = c;
        4'h8: cond_true = 1'b1;
        4'h9: cond_true = ~(s ^ v);
        4'hA: cond_true = ~(z | (s ^ v));
        4'hB: cond_true = ~(c | z);
        4'hC: cond_true = ~v;
        4'hD: cond_true = ~s;
        4'hE: cond_true = ~z;
        default: cond_true = ~c;
      endcase
    end
  endfunction

  always @*
  begin
    result    = dst;
    result_we = 1'b0;
    flags_out = flags_in;
    case (size)
      `STTX_SZ_BYTE:
      begin
        dif = {dst[31:8], sb[7:0]};
        cy  = sb[8];
        rm  = sb[7];
        dm  = dst[7];
        sm  = src[7];
        zz  = (sb[7:0] == 8'h00);
        pz  = (dst[7:0] == 8'h00);
        ps  = dst[7];
      end
      `STTX_SZ_WORD:
      begin
        dif = {dst[31:16], sw[15:0]};
        cy  = sw[16];
        rm  = sw[15];
        dm  = dst[15];
        sm  = src[15];
        zz  = (sw[15:0] == 16'h0000);
        pz  = (dst[15:0] == 16'h0000);
        ps  = dst[15];
      end
      default:
      begin
        dif = sl[31:0];
        cy  = sl[32];
        rm  = sl[31];
        dm  = dst[31];
        sm  = src[31];
        zz  = (sl[31:0] == 32'h00000000);
        pz  = (dst == 32'h00000000);
        ps  = dst[31];
      end
    endcase
    case (op)
      `STTX_OP_MINUS:
      begin
        result    = dif;
        result_we = 1'b1;
        flags_out[`STTX_FL_C] = ~cy;
        flags_out[`STTX_FL_Z] = zz;
        flags_out[`STTX_FL_S] = rm;
        flags_out[`STTX_FL_V] = (dm != sm) && (rm == sm);
        if (size == `STTX_SZ_BYTE)
        begin
          flags_out[`STTX_FL_D] = 1'b1;
          flags_out[`STTX_FL_H] = ~nib[4];
        end
      end
      `STTX_OP_PROBE:
      begin
        flags_out[`STTX_FL_Z] = pz;
        flags_out[`STTX_FL_S] = ps;
        if (size == `STTX_SZ_BYTE)
          flags_out[`STTX_FL_V] = ~^dst[7:0];
      end
      `STTX_OP_CBSET:
      begin
        if (cond_true(cond, flags_in))
        begin
          result    = {dst[31:1], 1'b1};
          result_we = 1'b1;
        end
      end
      default:
      begin
        result_we = 1'b0;
      end
    endcase
  end

endmodule

// >>> verif/sttx_mem_model.sv
`timescale 1ns/1ps
// Far-side byte memory; slow mode stalls
module sttx_mem_model (
  input  wire logic        ref_clk,  // Clock
  input  wire logic        rst,      // Async reset, active high
  input  wire logic        slow,     // Stall mode
  input  wire logic        rd_valid, // Read request
  input  wire logic [15:0] rd_addr,  // Read address
  output logic             rd_ack,   // Read done
  output logic      [7:0]  rd_data,  // Read byte
  input  wire logic        wr_valid, // Write request
  input  wire logic [15:0] wr_addr,  // Write address
  input  wire logic [7:0]  wr_data,  // Write byte
  output logic             wr_ready  // Write taken
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  logic [1:0] rwait_ff;
  logic [4:0] wtick_ff;

  // Idle read data shows the inverse of the last byte
  always_comb
  begin
    rd_ack   = rd_valid && (!slow || rwait_ff == 2'h3);
    wr_ready = !slow || wtick_ff == 5'h00;
    rd_data  = rd_ack ? mem[rd_addr] : ~last_ff;
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      last_ff  <= 8'h00;
      rwait_ff <= 2'h0;
      wtick_ff <= 5'h00;
    end
    else
    begin
      rwait_ff <= (rd_valid && !rd_ack) ? rwait_ff + 2'h1 : 2'h0;
      wtick_ff <= wtick_ff + 5'h01;
      if (rd_ack)
        last_ff <= rd_data;
      if (wr_valid && wr_ready)
        mem[wr_addr] <= wr_data;
    end
  end
endmodule

// >>> verif/sttx_exec_chk.sv
`timescale 1ns/1ps
module sttx_exec_chk (
  input wire        ref_clk,   // Clock
  input wire        rst,       // Async reset
  input wire        start,     // Start request
  input wire [2:0]  op,        // Operation code
  input wire [1:0]  size,      // Operand size
  input wire [5:0]  flags_in,  // Flags at start
  input wire [15:0] ptr_in,    // Pointer at start
  input wire [15:0] cnt_in,    // Counter at start
  input wire [15:0] pc_in,     // Start address
  input wire        rd_valid,  // Read request
  input wire        rd_ack,    // Read done
  input wire [15:0] rd_addr,   // Read address
  input wire        busy,      // Busy
  input wire        done,      // Done pulse
  input wire        result_we, // Result write
  input wire [5:0]  flags_out, // Result flags
  input wire [15:0] ptr_out,   // Pointer out
  input wire [15:0] cnt_out,   // Counter out
  input wire        irq_ack,   // Interrupt taken
  input wire [15:0] resume_pc  // Resume address
);
  reg [2:0]  op_ff;
  reg [5:0]  fl_ff;
  reg [15:0] ptr_ff;
  reg [15:0] cnt_ff;
  reg [15:0] pc_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Operands at acceptance
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      op_ff  <= 3'h0;
      fl_ff  <= 6'h00;
      ptr_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      pc_ff  <= 16'h0000;
    end
    else if (start && !busy)
    begin
      op_ff  <= op;
      fl_ff  <= flags_in;
      ptr_ff <= ptr_in;
      cnt_ff <= cnt_in;
      pc_ff  <= pc_in;
    end
  end

  property p_sub_lat;
    start && !busy && op == 3'h0 && size != 2'h2 |-> ##1 !done [*4] ##1 done && result_we;
  endproperty
  a_sub_lat: assert property (p_sub_lat) else $error("subtract done timing");
  property p_cbset_lat;
    start && !busy && op == 3'h2 |-> ##6 done;
  endproperty
  a_cbset_lat: assert property (p_cbset_lat) else $error("cond set done timing");
  property p_cbset_fl;
    done && op_ff == 3'h2 |-> flags_out == fl_ff;
  endproperty
  a_cbset_fl: assert property (p_cbset_fl) else $error("cond set changed flags");
  property p_probe;
    done && op_ff == 3'h1 |-> !result_we && flags_out[5] == fl_ff[5]
      && flags_out[1:0] == fl_ff[1:0];
  endproperty
  a_probe: assert property (p_probe) else $error("probe wrote or touched C D H");
  property p_xl_step;
    done && (op_ff == 3'h3 || op_ff == 3'h5) |-> cnt_out == cnt_ff - 16'h0001
      && flags_out[2] == (cnt_ff == 16'h0001);
  endproperty
  a_xl_step: assert property (p_xl_step) else $error("single step count or V");
  property p_xl_dir;
    done && (op_ff == 3'h3 || op_ff == 3'h5) |->
      ptr_out == (op_ff == 3'h5 ? ptr_ff + 16'h0001 : ptr_ff - 16'h0001);
  endproperty
  a_xl_dir: assert property (p_xl_dir) else $error("pointer direction");
  property p_xl_keep;
    done && op_ff >= 3'h3 |-> {flags_out[5], flags_out[3], flags_out[1:0]}
      == {fl_ff[5], fl_ff[3], fl_ff[1:0]};
  endproperty
  a_xl_keep: assert property (p_xl_keep) else $error("translate touched C S D H");
  property p_rep_end;
    done && op_ff == 3'h4 && cnt_out == 16'h0000 |-> flags_out[2];
  endproperty
  a_rep_end: assert property (p_rep_end) else $error("repeat end without V");
  property p_irq;
    irq_ack |-> resume_pc == pc_ff ##7 done;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt exit");
  property p_rd_hold;
    rd_valid && !rd_ack |=> rd_valid && $stable(rd_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");

  c_irq: cover property (irq_ack);
  c_rep: cover property (done && op_ff == 3'h4);
  c_busy_start: cover property (start && busy);
endmodule

bind sttx_exec sttx_exec_chk chk_u (.ref_clk, .rst, .start, .op, .size, .flags_in, .ptr_in,
  .cnt_in, .pc_in, .rd_valid, .rd_ack, .rd_addr, .busy, .done, .result_we, .flags_out,
  .ptr_out, .cnt_out, .irq_ack, .resume_pc);

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [1:0]  kind;
    logic [31:0] res;
    logic        we;
    logic [5:0]  fl;
    logic [5:0]  fm;
    logic [15:0] ptr;
    logic [15:0] cnt;
  } sttx_note_t;
  logic        ref_clk, rst, start, irq_req, slow, rd_ack, wr_ready, rd_valid, wr_valid;
  logic        busy, done, result_we, scratch_we, irq_ack;
  logic [2:0]  op;
  logic [1:0]  size;
  logic [3:0]  cond;
  logic [31:0] dst_val, src_val, result;
  logic [5:0]  flags_in, flags_out;
  logic [15:0] ptr_in, base_in, cnt_in, pc_in, rd_addr, wr_addr, ptr_out, cnt_out, resume_pc;
  logic [7:0]  rd_data, wr_data, scr;
  logic [7:0]  want [logic [15:0]];
  sttx_note_t  q [$];
  sttx_note_t  nt, mn;
  int          n_errors, checks, cyc, hold, k, idle;

  sttx_exec dut_u (.ref_clk, .rst, .start, .op, .size, .cond, .dst_val, .src_val, .flags_in,
    .ptr_in, .base_in, .cnt_in, .pc_in, .irq_req, .rd_ack, .rd_data, .wr_ready, .rd_valid,
    .rd_addr, .wr_valid, .wr_addr, .wr_data, .busy, .done, .result, .result_we, .flags_out,
    .ptr_out, .cnt_out, .scratch_high_byte_reg(scr), .scratch_we, .irq_ack, .resume_pc);
  sttx_mem_model mem_u (.ref_clk, .rst, .slow, .rd_valid, .rd_addr, .rd_ack, .rd_data,
    .wr_valid, .wr_addr, .wr_data, .wr_ready);

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task tally_and_finish;
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic sttx_note_t alu_exp(input [2:0] o, input [1:0] sz, input [31:0] d, s,
                                          input [5:0] f, input [3:0] cc);
    int         w;
    logic [32:0] m, r;
    logic        b;
    sttx_note_t  n;
    w = sz == 2'h0 ? 8 : sz == 2'h1 ? 16 : 32;
    m = (33'h1 << w) - 33'h1;
    r = ({1'b0, d} & m) - ({1'b0, s} & m);
    n = '0;
    n.fl = f;
    n.fm = 6'h3F;
    if (o == 3'h0)
    begin
      n.we = 1'b1;
      n.res = (d & ~m[31:0]) | (r[31:0] & m[31:0]);
      n.fl[5] = r[w];
      n.fl[4] = (r[31:0] & m[31:0]) == 32'h0;
      n.fl[3] = r[w-1];
      n.fl[2] = (d[w-1] != s[w-1]) && (r[w-1] == s[w-1]);
      if (sz == 2'h0)
        n.fl[1:0] = {1'b1, d[3:0] < s[3:0]};
    end
    else if (o == 3'h1)
    begin
      n.fl[4] = (d & m[31:0]) == 32'h0;
      n.fl[3] = d[w-1];
      if (sz == 2'h0)
        n.fl[2] = ~^d[7:0];
      if (sz == 2'h2)
        n.fm = 6'h3B;
    end
    else
    begin
      case (cc[2:0])
        3'h0: b = 1'b0;
        3'h1: b = f[3] ^ f[2];
        3'h2: b = f[4] | (f[3] ^ f[2]);
        3'h3: b = f[5] | f[4];
        3'h4: b = f[2];
        3'h5: b = f[3];
        3'h6: b = f[4];
        default: b = f[5];
      endcase
      n.we = b ^ cc[3];
      n.res = d | 32'h1;
    end
    return n;
  endfunction

  task go;
    start = 1'b1;
    cyc = 0;
    do
    begin
      @(negedge ref_clk);
      cyc++;
      if (cyc == hold)
        start = 1'b0;
    end while (done !== 1'b1 && cyc < 3000);
    chk(done === 1'b1, "no done");
    hold = 1;
  endtask

  task prep(input [2:0] o, input [15:0] p, c, input int nb);
    logic [15:0] a;
    op = o;
    ptr_in = p;
    cnt_in = c;
    base_in = 16'h1000;
    flags_in = 6'($urandom);
    pc_in = 16'($urandom);
    for (int i = 0; i < nb; i++)
    begin
      a = o == 3'h5 ? p + 16'(i) : p - 16'(i);
      mem_u.mem[a] = 8'($urandom);
      want[a] = mem_u.mem[16'h1000 + {8'h00, mem_u.mem[a]}];
    end
    nt = '0;
    nt.kind = 2'h1;
    nt.fl = flags_in;
    nt.fl[2] = o == 3'h4 ? 1'b1 : c == 16'h0001;
    nt.fm = 6'h2F;
    nt.ptr = o == 3'h5 ? p + 16'h0001 : p - 16'(nb);
    nt.cnt = o == 3'h4 ? 16'h0000 : c - 16'h0001;
  endtask

  task drain;
    k = 0;
    idle = 0;
    while (idle < 8 && k < 5000)
    begin
      @(negedge ref_clk);
      k++;
      idle = wr_valid === 1'b0 ? idle + 1 : 0;
    end
    foreach (want[a])
      chk(mem_u.mem[a] === want[a], "translated byte");
    want.delete();
  endtask

  task xl(input [2:0] o, input [15:0] p, c, input int nb);
    prep(o, p, c, nb);
    q.push_back(nt);
    go;
    chk(cyc - 1 == (o == 3'h4 ? 11 + 14 * nb : 25), "translate cycles");
    drain;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk)
  begin
    if (irq_ack === 1'b1)
      chk(resume_pc === pc_in, "resume address");
    if (scratch_we === 1'b1)
      chk(busy === 1'b1 && op >= 3'h3, "scratch write");
    if (done === 1'b1)
    begin
      chk(q.size() > 0, "unexpected done");
      if (q.size() > 0)
      begin
        mn = q.pop_front();
        chk(((flags_out ^ mn.fl) & mn.fm) === 6'h00, "flags");
        if (mn.kind == 2'h0)
          chk(result_we === mn.we && (!mn.we || result === mn.res), "result");
        if (mn.kind == 2'h1)
          chk(ptr_out === mn.ptr && cnt_out === mn.cnt, "pointer or count");
      end
    end
  end

  initial
  begin
    #1500000;
    n_errors++;
    tally_and_finish;
  end

  initial
  begin
    {rst, start, irq_req, slow, op, size, cond, dst_val, src_val, flags_in} = '0;
    {ptr_in, base_in, cnt_in, pc_in, n_errors, checks, hold} = '0;
    hold = 1;
    rst = 1'b1;
    void'($urandom(32'h1ae6));
    for (int i = 0; i < 256; i++)
      mem_u.mem[16'h1000 + 16'(i)] = 8'($urandom);
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 46; i++)
    begin
      op = i < 12 ? 3'h0 : i < 30 ? 3'h1 : 3'h2;
      size = 2'(i % 3);
      cond = 4'(i - 30);
      src_val = $urandom;
      dst_val = (i == 1) ? src_val : (i >= 12 && i < 15) ? 32'h0 : $urandom;
      flags_in = 6'($urandom);
      hold = i == 0 ? 2 : 1;
      q.push_back(alu_exp(op, size, dst_val, src_val, flags_in, cond));
      go;
    end
    xl(3'h3, 16'h4001, 16'h0001, 1);
    xl(3'h5, 16'h5000, 16'h0000, 1);
    xl(3'h3, 16'h4100, 16'h0005, 1);
    xl(3'h4, 16'h4200, 16'h0004, 4);
    prep(3'h4, 16'h4400, 16'h0014, 20);
    nt.kind = 2'h2;
    nt.fl[2] = 1'b0;
    q.push_back(nt);
    slow = 1'b1;
    fork
      go;
      begin
        repeat (60) @(negedge ref_clk);
        irq_req = 1'b1;
        for (k = 0; k < 3000 && irq_ack !== 1'b1; k++)
          @(negedge ref_clk);
        irq_req = 1'b0;
      end
    join
    chk(cnt_out !== 16'h0000, "repeat not interrupted");
    ptr_in = ptr_out;
    cnt_in = cnt_out;
    nt.kind = 2'h1;
    nt.fl[2] = 1'b1;
    nt.ptr = 16'h4400 - 16'd20;
    nt.cnt = 16'h0000;
    q.push_back(nt);
    go;
    drain;
    tally_and_finish;
  end
endmodule
